// ### logic/gtf_map.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef GTF_MAP_SVH
`define GTF_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define GTF_OFF_CFG       12'h08C
`define GTF_OFF_CNT       12'h090
`define GTF_OFF_FREE      12'h09C
`define GTF_OFF_IRQ_STS   12'h0A0
`define GTF_OFF_IRQ_CLR   12'h0A4
`define GTF_OFF_IRQ_EN    12'h0A8

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define GTF_CFG_EN_BIT    29
`define GTF_LOAD_MSB      15
`define GTF_LOAD_RST      16'hFFFF
`define GTF_CNT_RST       16'hFFFF
`define GTF_FREE_RST      32'h0000_0000
`define GTF_IRQ_WRAP_BIT  0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define GTF_PCLK_MHZ      250
`define GTF_FREE_MHZ      25
`define GTF_FREE_DIV      (`GTF_PCLK_MHZ / `GTF_FREE_MHZ)
`define GTF_CLR_MAX_NS    160
`define GTF_PCLK_NS       4
`define GTF_CLR_MAX_CYC   (`GTF_CLR_MAX_NS / `GTF_PCLK_NS)
`define GTF_TICK_DIV      250

`endif

// ### logic/gtf_pkg.sv
// Types shared by the timer block
package gtf_pkg;
    typedef enum logic [1:0] {
        GTF_ST_HALT = 2'b01,
        GTF_ST_RUN  = 2'b10
    } gtf_state_t;
endpackage

// ### logic/gtf_free_counter.sv
// Free-running counter advanced on a 25 MHz enable derived from pclk
`timescale 1ns/10ps
`include "gtf_map.svh"
module gtf_free_counter
    import gtf_pkg::*;
#(
    parameter int DIV = `GTF_FREE_DIV
) (
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, active low
    output logic      [31:0] count     // Present count
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DIV < 1 || DIV > 255) begin : g_bad_div
        $error("gtf_free_counter: DIV out of range");
    end

    logic [7:0]  div_q;
    logic [31:0] count_q;
    wire         step = (div_q == 8'(DIV - 1));

    // ------------------------------------------------------------
    // Counter; reset gives zero at once, well inside the clear limit
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q   <= 8'h00;
            count_q <= `GTF_FREE_RST;
        end else begin
            div_q <= step ? 8'h00 : div_q + 8'h01;
            if (step) begin
                count_q <= count_q + 32'h0000_0001;
            end
        end
    end

    assign count = count_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_free_step;
        @(posedge pclk) disable iff (!presetn)
        step |=> count_q == $past(count_q) + 32'h0000_0001;
    endproperty
    a_free_step: assert property (p_free_step) else $error("free count did not step");

    property p_free_hold;
        @(posedge pclk) disable iff (!presetn)
        !step |=> $stable(count_q);
    endproperty
    a_free_hold: assert property (p_free_hold) else $error("free count moved off tick");
endmodule

// ### logic/gtf_timer.sv
// General timer, free-running counter and their APB register file
//
// Operation
// - Timer counts while enable bit set, holds its state when clear.
// - Enable bit reads zero after reset.
// - Enable falling from one to zero forces preload to all ones.
// - Preload bits 15:0 are the start value; timer counts down from it.
// - Timer raises an interrupt each time the preload interval elapses.
// - Read-only count field gives present timer value, all ones after reset.
// - Software reads a 32-bit free-running counter; writes are ignored.
// - Free counter starts at zero and adds one each 25 MHz cycle.
// - Free counter wraps from maximum to zero and keeps counting.
// - Free count is captured on read so the word is consistent.
// - Free counter is zero within 160 ns of reset.
`timescale 1ns/10ps
`include "gtf_map.svh"
module gtf_timer
    import gtf_pkg::*;
#(
    parameter int TICK_DIV = `GTF_TICK_DIV
) (
    input  wire logic        pclk,     // System clock, 250 MHz
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB direction
    input  wire logic [11:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    input  wire logic [3:0]  pstrb,    // APB byte strobes
    output logic             pready,   // APB ready
    output logic      [31:0] prdata,   // APB read data
    output logic             pslverr,  // APB error on unmapped address
    output logic             irq       // Level interrupt
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_tick
        $error("gtf_timer: TICK_DIV out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    gtf_state_t  state_q;
    gtf_state_t  state_d;
    logic        en_q;
    logic [15:0] load_q;
    logic [15:0] cnt_q;
    logic [15:0] tick_q;
    logic        sts_q;
    logic        irq_en_q;
    logic [31:0] rdata_q;
    logic [31:0] free_cnt;

    // Merge a write with byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // APB decode; slave always answers in the access cycle
    // ------------------------------------------------------------
    wire acc      = psel && penable;
    wire hit_cfg  = (paddr == `GTF_OFF_CFG);
    wire hit_cnt  = (paddr == `GTF_OFF_CNT);
    wire hit_free = (paddr == `GTF_OFF_FREE);
    wire hit_sts  = (paddr == `GTF_OFF_IRQ_STS);
    wire hit_clr  = (paddr == `GTF_OFF_IRQ_CLR);
    wire hit_ien  = (paddr == `GTF_OFF_IRQ_EN);
    wire mapped   = hit_cfg | hit_cnt | hit_free | hit_sts | hit_clr | hit_ien;
    wire wr_cfg   = acc && pwrite && hit_cfg;
    wire wr_clr   = acc && pwrite && hit_clr;
    wire wr_ien   = acc && pwrite && hit_ien;
    wire rd_setup = psel && !penable && !pwrite;

    // Config word as seen by software, reserved bits zero
    wire [31:0] cfg_word = {2'b00, en_q, 13'h0000, load_q};
    wire [31:0] cfg_new  = merge(cfg_word, pwdata, pstrb);
    wire        en_new   = wr_cfg ? cfg_new[`GTF_CFG_EN_BIT] : en_q;
    wire        en_fall  = en_q && !en_new;
    // Preload as it stands after this edge, so a start uses the value written with the enable
    wire [15:0] load_nxt = en_fall ? `GTF_LOAD_RST : wr_cfg ? cfg_new[`GTF_LOAD_MSB:0] : load_q;

    // Tick divider and underflow
    wire        tick     = (tick_q == 16'(TICK_DIV - 1));
    wire        running  = (state_q == GTF_ST_RUN);
    wire        wrap     = running && tick && (cnt_q == 16'h0000);

    // ------------------------------------------------------------
    // Read mux; value captured in setup so the access sees one snapshot
    // ------------------------------------------------------------
    wire [31:0] rd_mux = hit_cfg  ? cfg_word :
                         hit_cnt  ? {16'h0000, cnt_q} :
                         hit_free ? free_cnt :
                         hit_sts  ? {31'h0, sts_q} :
                         hit_ien  ? {31'h0, irq_en_q} : 32'h0000_0000;

    // ------------------------------------------------------------
    // Free-running counter
    // ------------------------------------------------------------
    gtf_free_counter #(
        .DIV (`GTF_FREE_DIV)
    ) u_free (
        .pclk    (pclk),
        .presetn (presetn),
        .count   (free_cnt)
    );

    // ------------------------------------------------------------
    // Timer state machine
    // ------------------------------------------------------------
    always_comb begin
        case (state_q)
            GTF_ST_HALT: state_d = en_new ? GTF_ST_RUN : GTF_ST_HALT;
            GTF_ST_RUN:  state_d = en_new ? GTF_ST_RUN : GTF_ST_HALT;
            default:     state_d = GTF_ST_HALT;
        endcase
    end

    // Config register; preload forced high on disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q   <= 1'b0;
            load_q <= `GTF_LOAD_RST;
        end else begin
            en_q <= en_new;
            if (en_fall) begin
                load_q <= `GTF_LOAD_RST;
            end else if (wr_cfg) begin
                load_q <= cfg_new[`GTF_LOAD_MSB:0];
            end
        end
    end

    // Counter; enabling from halt starts from the preload value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= GTF_ST_HALT;
            cnt_q   <= `GTF_CNT_RST;
            tick_q  <= 16'h0000;
        end else begin
            state_q <= state_d;
            if (!running) begin
                tick_q <= 16'h0000;
                if (en_new) begin
                    cnt_q <= load_nxt;
                end
            end else begin
                tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
                if (tick) begin
                    cnt_q <= wrap ? load_q : cnt_q - 16'h0001;
                end
            end
        end
    end

    // Interrupt status; a new wrap wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q    <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (wrap) begin
                sts_q <= 1'b1;
            end else if (wr_clr && pstrb[0] && pwdata[`GTF_IRQ_WRAP_BIT]) begin
                sts_q <= 1'b0;
            end
            if (wr_ien && pstrb[0]) begin
                irq_en_q <= pwdata[`GTF_IRQ_WRAP_BIT];
            end
        end
    end

    // Read data latched at setup; the free count cannot tear in the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_q <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = rdata_q;
    assign irq     = sts_q && irq_en_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fall;
        en_q ##1 !en_q;
    endsequence

    property p_preload_force;
        @(posedge pclk) disable iff (!presetn)
        s_fall |-> load_q == 16'hFFFF;
    endproperty
    a_preload_force: assert property (p_preload_force) else $error("preload not forced on disable");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!en_q && !en_new) |=> $stable(cnt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved while disabled");

    property p_dec;
        @(posedge pclk) disable iff (!presetn)
        (running && tick && cnt_q != 16'h0000) |=> cnt_q == $past(cnt_q) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("timer did not decrement");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        wrap |=> (sts_q && cnt_q == $past(load_q));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not reload or flag");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (wrap && irq_en_q && !wr_ien) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing after wrap");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (!running && en_new) |=> cnt_q == load_q;
    endproperty
    a_start: assert property (p_start) else $error("start not from preload");

    property p_read_snap;
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && hit_free) |=> prdata == $past(free_cnt);
    endproperty
    a_read_snap: assert property (p_read_snap) else $error("free count read not captured");

    property p_cnt_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && hit_cnt) |=> prdata == {16'h0000, $past(cnt_q)};
    endproperty
    a_cnt_read: assert property (p_cnt_read) else $error("count read mismatch");

    property p_en_reset;
        @(posedge pclk) $rose(presetn) |-> !en_q && free_cnt == 32'h0000_0000;
    endproperty
    a_en_reset: assert property (p_en_reset) else $error("reset values wrong");

    property p_cnt_reset;
        @(posedge pclk) $rose(presetn) |-> cnt_q == `GTF_CNT_RST && load_q == `GTF_LOAD_RST;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("count or preload reset value wrong");

    property p_load_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_cfg && !en_fall) |=> load_q == $past(cfg_new[`GTF_LOAD_MSB:0]);
    endproperty
    a_load_write: assert property (p_load_write) else $error("preload write lost");

    property p_en_write;
        @(posedge pclk) disable iff (!presetn)
        wr_cfg |=> en_q == $past(cfg_new[`GTF_CFG_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_run_en;
        @(posedge pclk) disable iff (!presetn)
        running == en_q;
    endproperty
    a_run_en: assert property (p_run_en) else $error("run state differs from enable bit");

    // A clear only takes effect when no wrap lands in the same cycle
    sequence s_clear;
        wr_clr && pstrb[0] && pwdata[`GTF_IRQ_WRAP_BIT] && !wrap;
    endsequence

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        s_clear |=> !sts_q;
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared");

    property p_sticky;
        @(posedge pclk) disable iff (!presetn)
        (sts_q && !wr_clr) |=> sts_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("status flag dropped");

    property p_rd_hold;
        @(posedge pclk) disable iff (!presetn)
        !rd_setup |=> $stable(prdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule

// ### tb/general_timer_and_free_counter_bench.sv
// Self-checking bench for the timer, free counter and their register file
`timescale 1ns/10ps
`include "gtf_map.svh"
module general_timer_and_free_counter_bench;
    import gtf_pkg::*;
    localparam int TDIV = 2;           // Short tick keeps intervals to a few cycles
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'hF;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic [31:0] rv, r2, lfsr, m_cfg;
    logic        re;
    int          fail_count = 0;
    int          checks     = 0;
    int          n;
    int          ncyc = 0;       // Edges out of reset, time base of the models
    int          ts, ta, tw;     // Setup and access edges of the last transfer, access edge of the enabling write
    logic [31:0] fm;             // Modelled free count at the last setup edge

    gtf_timer #(.TICK_DIV(TDIV)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq(irq));

    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        forever #2 pclk = ~pclk;
    end
    // Whole run needs a few hundred cycles; generous margin before giving up
    initial begin
        #80000;
        fail_count++;
        final_report();
    end
    // Edge count since reset release; the free count steps every tenth edge
    always @(posedge pclk) begin
        ncyc <= presetn ? ncyc + 1 : 0;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; the model of the config word follows every accepted write
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int          k;
        logic [31:0] mk;
        logic [31:0] dm;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        ts = ncyc;
        fm = ncyc / `GTF_FREE_DIV;
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        chk("pready", 32'h1, {31'h0, pready});
        chk("pready_wait", 32'd1, k);
        ta = ncyc;
        rv = prdata;
        re = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (w && a == `GTF_OFF_CFG) begin
            mk = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
            dm = (d & mk) | (m_cfg & ~mk);
            if (m_cfg[29] && !dm[29]) m_cfg = {dm[31:16] & 16'h2000, 16'hFFFF};
            else m_cfg = dm & 32'h2000_FFFF;
        end
    endtask
    task automatic gap(input int c);
        repeat (c) @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        m_cfg = 32'h0000_FFFF;
        lfsr  = 32'd69727;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values
        apb(0, `GTF_OFF_CFG, 0);  chk("cfg_rst", m_cfg, rv);
        apb(0, `GTF_OFF_CNT, 0);  chk("cnt_rst", 32'h0000_FFFF, rv);
        apb(0, `GTF_OFF_FREE, 0); chk("free_rst", fm, rv);
        apb(0, `GTF_OFF_IRQ_STS, 0); chk("sts_rst", 0, rv);
        chk("irq_rst", 0, irq);
        $display("test reset done");
        // Read-only places and an unmapped address
        apb(1, `GTF_OFF_CNT, 32'h1234_5678);
        apb(0, `GTF_OFF_CNT, 0);  chk("cnt_ro", 32'h0000_FFFF, rv);
        apb(1, `GTF_OFF_FREE, 32'hFFFF_FFF0);
        apb(0, `GTF_OFF_FREE, 0); chk("free_ro", fm, rv);
        apb(1, 12'h100, 32'hA5A5_A5A5); chk("err_wr", 1, re);
        apb(0, 12'h100, 0); chk("err_rd", 1, re);
        chk("err_rdata", 0, rv);
        $display("test access done");
        // Random preload values with the timer halted read back masked
        repeat (4) begin
            lfsr = nxt(lfsr);
            apb(1, `GTF_OFF_CFG, lfsr & 32'hDFFF_FFFF);
            apb(0, `GTF_OFF_CFG, 0); chk("cfg_rand", m_cfg, rv);
        end
        // Byte strobes: only the low preload byte takes this write
        pstrb <= 4'h1;
        apb(1, `GTF_OFF_CFG, 32'hFFFF_FF5A);
        pstrb <= 4'hF;
        apb(0, `GTF_OFF_CFG, 0); chk("cfg_strb", m_cfg, rv);
        $display("test preload done");
        // Free counter: setups 40 cycles apart see exactly four 25 MHz steps
        apb(0, `GTF_OFF_FREE, 0); r2 = rv;
        gap(37);
        apb(0, `GTF_OFF_FREE, 0); chk("free_step", r2 + 32'd4, rv);
        $display("test free done");
        // Running timer counts down one per tick and holds when halted
        apb(1, `GTF_OFF_CFG, 32'h2000_1000);
        tw = ta;
        apb(0, `GTF_OFF_CFG, 0); chk("cfg_run", m_cfg, rv);
        apb(0, `GTF_OFF_CNT, 0); r2 = rv;
        // Start value is the preload written with the enable, less one per tick since
        chk("cnt_start", 32'h0000_1000 - (ts - tw - 1) / TDIV, r2);
        gap(37);
        apb(0, `GTF_OFF_CNT, 0); chk("cnt_step", r2 - 32'd20, rv);
        apb(1, `GTF_OFF_CFG, 32'h0000_1000);
        apb(0, `GTF_OFF_CFG, 0); chk("cfg_stop", m_cfg, rv);
        apb(0, `GTF_OFF_CNT, 0); r2 = rv;
        gap(20);
        apb(0, `GTF_OFF_CNT, 0); chk("cnt_hold", r2, rv);
        $display("test run done");
        // Interrupt raised, cleared, then masked
        apb(1, `GTF_OFF_IRQ_EN, 32'h1);
        apb(1, `GTF_OFF_CFG, 32'h2000_0003);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        chk("irq_raised", 1, irq);
        apb(0, `GTF_OFF_CNT, 0); chk("cnt_reload", 1, rv <= 32'h3);
        apb(1, `GTF_OFF_CFG, 32'h0);
        apb(0, `GTF_OFF_IRQ_STS, 0); chk("sts_set", 1, rv);
        apb(1, `GTF_OFF_IRQ_CLR, 32'h1);
        apb(0, `GTF_OFF_IRQ_STS, 0); chk("sts_clr", 0, rv);
        chk("irq_clr", 0, irq);
        apb(1, `GTF_OFF_IRQ_EN, 32'h0);
        apb(1, `GTF_OFF_CFG, 32'h2000_0003);
        gap(30);
        apb(0, `GTF_OFF_IRQ_STS, 0); chk("sts_masked", 1, rv);
        chk("irq_masked", 0, irq);
        apb(1, `GTF_OFF_CFG, 32'h0);
        apb(1, `GTF_OFF_IRQ_CLR, 32'h1);
        $display("test irq done");
        // Reset in mid-run with the timer going brings back the config, count and free reset values
        apb(1, `GTF_OFF_CFG, 32'h2000_0010);
        gap(5);
        presetn <= 1'b0;
        gap(3);
        presetn <= 1'b1;
        m_cfg = 32'h0000_FFFF;
        apb(0, `GTF_OFF_CFG, 0);  chk("cfg_rst2", m_cfg, rv);
        apb(0, `GTF_OFF_CNT, 0);  chk("cnt_rst2", 32'h0000_FFFF, rv);
        apb(0, `GTF_OFF_FREE, 0); chk("free_rst2", fm, rv);
        $display("test mid-run reset done");
        final_report();
    end
endmodule
